// File: design/see_pkg.sv
// Shared constants for the serial EEPROM link and its master
package see_pkg;
  // ----------------------------------------
  // Opcodes
  // ----------------------------------------
  localparam logic [7:0] OP_LATCH_SET = 8'h06;
  localparam logic [7:0] OP_LATCH_CLR = 8'h04;
  localparam logic [7:0] OP_STAT_RD = 8'h05;
  localparam logic [7:0] OP_STAT_WR = 8'h01;
  localparam logic [7:0] OP_ARR_RD = 8'h03;
  localparam logic [7:0] OP_ARR_WR = 8'h02;
  // ----------------------------------------
  // Geometry and reset values
  // ----------------------------------------
  localparam int ADDR_W = 9;
  localparam int PAGE_BITS = 4;
  localparam int MEM_DEPTH = 512;
  localparam logic [7:0] ERASED_BYTE = 8'hFF;
  localparam logic [1:0] PROT_DELIVERED = 2'h0;
  localparam logic [3:0] STAT_TOP = 4'hF;
  // ----------------------------------------
  // Programming time and serial clock half period
  // ----------------------------------------
  localparam int PROG_TIME_US = 10000;
  localparam int CLK_MHZ = 100;
  localparam int PROG_CYCLES = PROG_TIME_US * CLK_MHZ;
  localparam int LATCH_CLR_LEAD = 4;
  localparam int SCK_HALF = 6;
  // ----------------------------------------
  // Master register map (APB)
  // ----------------------------------------
  localparam logic [7:0] REG_CTRL = 8'h00;
  localparam logic [7:0] REG_TXD = 8'h04;
  localparam logic [7:0] REG_RXD = 8'h08;
  localparam logic [7:0] REG_STAT = 8'h0C;
  localparam logic [7:0] REG_IRQ = 8'h10;
  localparam logic [7:0] REG_MASK = 8'h14;
  localparam int CTRL_GO = 0;
  localparam int CTRL_LAST = 1;
  localparam int CTRL_HOLD = 2;
  localparam int CTRL_GUARD = 3;
endpackage

// File: design/see_if.sv
// Serial link between master and EEPROM
`timescale 1ns/10ps
interface see_if;
  logic sck;
  logic chip_enable_n;
  logic serial_in;
  logic hold_n;
  logic program_guard_n;
  logic serial_out_o;
  logic serial_out_oe;
  logic serial_out;
  assign serial_out = serial_out_oe ? serial_out_o : 1'b1;
  modport mem (input sck, input chip_enable_n, input serial_in, input hold_n, input program_guard_n,
    output serial_out_o, output serial_out_oe);
  modport mst (output sck, output chip_enable_n, output serial_in, output hold_n, output program_guard_n,
    input serial_out);
endinterface

// File: design/see_mem.sv
// Serial EEPROM device end: protocol, page write, timed programming
// What this block does
// - Master holds enable low through write
// - Byte write needs deselect after data
// - Programming starts when enable rises
// - Status readable, busy high while programming
// - Latch cleared near programming end
// - Page write takes at most 16 bytes
// - Page address wraps within 16 bytes
// - Write starts only on byte boundary
// - Power-up: idle, latch clear, protect reset to zero
// - Invalid enable or hold edges ignored
// - Array access while busy is rejected
// - Short commands then wait for deselect
// - Guard low clears write latch
// - Delivered array all ones, protect zero
// - Sample rising edge, drive falling edge
// - Decode the six eight-bit opcodes
// - Writes need latch set beforehand
// - Status layout ones, protect, latch, busy
`timescale 1ns/10ps
module see_mem
  import see_pkg::*;
#(
  parameter int PROG_CYC = PROG_CYCLES
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Serial link
  see_if.mem lnk
);
  typedef enum logic [6:0] {
    S_OP = 7'h01, S_ADDR = 7'h02, S_WDATA = 7'h04, S_RDATA = 7'h08,
    S_SDATA = 7'h10, S_SRD = 7'h20, S_WAIT = 7'h40
  } see_st_t;

  // ----------------------------------------
  // Input synchronisers
  // ----------------------------------------
  logic [1:0] sck_s_ff, cs_s_ff, si_s_ff, hold_s_ff, guard_s_ff;
  logic sck_d_ff, cs_d_ff;
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      sck_s_ff <= 2'h0;
      cs_s_ff <= 2'h3;
      si_s_ff <= 2'h0;
      hold_s_ff <= 2'h3;
      guard_s_ff <= 2'h3;
      sck_d_ff <= 1'b0;
      cs_d_ff <= 1'b1;
    end else begin
      sck_s_ff <= {sck_s_ff[0], lnk.sck};
      cs_s_ff <= {cs_s_ff[0], lnk.chip_enable_n};
      si_s_ff <= {si_s_ff[0], lnk.serial_in};
      hold_s_ff <= {hold_s_ff[0], lnk.hold_n};
      guard_s_ff <= {guard_s_ff[0], lnk.program_guard_n};
      sck_d_ff <= sck_s_ff[1];
      cs_d_ff <= cs_s_ff[1];
    end
  end
  wire logic cs_n = cs_s_ff[1];
  wire logic sck_rise = sck_s_ff[1] & ~sck_d_ff;
  wire logic sck_fall = ~sck_s_ff[1] & sck_d_ff;
  wire logic cs_rise = cs_n & ~cs_d_ff;

  // ----------------------------------------
  // Hold: only taken with clock low and selected
  // ----------------------------------------
  logic held_ff;
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      held_ff <= 1'b0;
    end else if (!cs_n && !sck_s_ff[1]) begin
      held_ff <= ~hold_s_ff[1];
    end
  end
  wire logic active = ~cs_n & ~held_ff;

  // ----------------------------------------
  // Storage, delivered state
  // ----------------------------------------
  logic [7:0] mem_ff [MEM_DEPTH];
  logic [7:0] page_ff [16];
  logic [15:0] page_vld_ff;
  logic [1:0] prot_ff;
  logic latch_ff, busy_ff;
  initial begin
    for (int i = 0; i < MEM_DEPTH; i++) mem_ff[i] = ERASED_BYTE;
  end

  // ----------------------------------------
  // Serial protocol
  // ----------------------------------------
  see_st_t st_ff;
  logic [2:0] bit_ff;
  logic [7:0] sh_ff, op_ff, tx_ff;
  logic [ADDR_W-1:0] addr_ff;
  logic armed_ff, wr_ok_ff, so_oe_ff, so_ff;
  logic [1:0] prot_new_ff;
  wire logic [7:0] rx = {sh_ff[6:0], si_s_ff[1]};
  wire logic byte_done = sck_rise && bit_ff == 3'h7;
  wire logic [7:0] status = {STAT_TOP, prot_ff, latch_ff, busy_ff};
  wire logic [ADDR_W-1:0] nxt_addr = {addr_ff[ADDR_W-1:PAGE_BITS], addr_ff[PAGE_BITS-1:0] + 4'h1};

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      st_ff <= S_OP;
      bit_ff <= 3'h0;
      sh_ff <= 8'h00;
      op_ff <= 8'h00;
      tx_ff <= 8'h00;
      addr_ff <= '0;
      armed_ff <= 1'b0;
      wr_ok_ff <= 1'b0;
      prot_new_ff <= 2'h0;
      page_vld_ff <= 16'h0;
    end else if (cs_n) begin
      st_ff <= S_OP;
      bit_ff <= 3'h0;
      if (cs_rise) armed_ff <= 1'b0;
    end else if (active && sck_rise) begin
      sh_ff <= rx;
      bit_ff <= bit_ff + 3'h1;
      // Armed only right after full byte
      armed_ff <= 1'b0;
      if (bit_ff == 3'h7) begin
        case (st_ff)
          S_OP: begin
            op_ff <= rx;
            addr_ff[ADDR_W-1] <= rx[3];
            // Opcode decode, bit 3 is address MSB
            case ({rx[7:4], 1'b0, rx[2:0]})
              OP_ARR_WR, OP_ARR_RD: begin
                st_ff <= busy_ff ? S_WAIT : S_ADDR;
                if (!busy_ff) page_vld_ff <= 16'h0;
              end
              OP_STAT_WR: begin
                st_ff <= busy_ff ? S_WAIT : S_SDATA;
                wr_ok_ff <= latch_ff;
              end
              OP_STAT_RD: begin
                st_ff <= S_SRD;
                tx_ff <= status;
              end
              default: st_ff <= S_WAIT;
            endcase
          end
          S_ADDR: begin
            addr_ff[ADDR_W-2:0] <= rx;
            wr_ok_ff <= latch_ff;
            if ({op_ff[7:4], 1'b0, op_ff[2:0]} == OP_ARR_WR) begin
              st_ff <= S_WDATA;
            end else begin
              st_ff <= S_RDATA;
              tx_ff <= mem_ff[{op_ff[3], rx}];
            end
          end
          S_WDATA: begin
            page_ff[addr_ff[PAGE_BITS-1:0]] <= rx;
            page_vld_ff[addr_ff[PAGE_BITS-1:0]] <= 1'b1;
            addr_ff <= nxt_addr;
            armed_ff <= wr_ok_ff && latch_ff;
          end
          S_SDATA: begin
            prot_new_ff <= rx[3:2];
            armed_ff <= wr_ok_ff && latch_ff;
            st_ff <= S_WAIT;
          end
          S_RDATA: begin
            addr_ff <= addr_ff + 9'h001;
            tx_ff <= mem_ff[addr_ff + 9'h001];
          end
          S_SRD: st_ff <= S_WAIT;
          default: st_ff <= S_WAIT;
        endcase
      end
    end else if (!guard_s_ff[1]) begin
      armed_ff <= 1'b0;
    end
  end

  // ----------------------------------------
  // Output on falling clock
  // ----------------------------------------
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      so_ff <= 1'b1;
      so_oe_ff <= 1'b0;
    end else if (!active) begin
      so_oe_ff <= 1'b0;
    end else if (sck_fall && (st_ff == S_SRD || st_ff == S_RDATA)) begin
      so_ff <= (st_ff == S_SRD && bit_ff == 3'h0) ? status[7] : tx_ff[3'h7 - bit_ff];
      so_oe_ff <= 1'b1;
    end else if (sck_fall) begin
      so_oe_ff <= 1'b0;
    end
  end
  assign lnk.serial_out_o = so_ff;
  assign lnk.serial_out_oe = so_oe_ff;

  // ----------------------------------------
  // Timed programming
  // ----------------------------------------
  logic [31:0] cnt_ff;
  logic is_stat_ff;
  logic [ADDR_W-PAGE_BITS-1:0] cpage_ff;
  wire logic start = cs_rise && armed_ff && !busy_ff && guard_s_ff[1] && !held_ff;
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      busy_ff <= 1'b0;
      cnt_ff <= 32'h0;
      is_stat_ff <= 1'b0;
      cpage_ff <= '0;
      prot_ff <= PROT_DELIVERED;
    end else if (start) begin
      busy_ff <= 1'b1;
      cnt_ff <= 32'(PROG_CYC);
      is_stat_ff <= (op_ff == OP_STAT_WR);
      cpage_ff <= addr_ff[ADDR_W-1:PAGE_BITS];
    end else if (busy_ff) begin
      cnt_ff <= cnt_ff - 32'h1;
      if (cnt_ff == 32'h1) begin
        busy_ff <= 1'b0;
        if (is_stat_ff) prot_ff <= prot_new_ff;
      end
    end
  end
  // Array commit on last cycle; block protect not applied here
  always_ff @(posedge clk) begin
    if (busy_ff && cnt_ff == 32'h1 && !is_stat_ff) begin
      for (int i = 0; i < 16; i++) begin
        if (page_vld_ff[i]) mem_ff[{cpage_ff, 4'(i)}] <= page_ff[i];
      end
    end
  end

  // ----------------------------------------
  // Write enable latch
  // ----------------------------------------
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      latch_ff <= 1'b0;
    end else if (!guard_s_ff[1]) begin
      latch_ff <= 1'b0;
    end else if (busy_ff && cnt_ff == 32'(LATCH_CLR_LEAD)) begin
      latch_ff <= 1'b0;
    end else if (active && byte_done && st_ff == S_OP) begin
      if (rx == OP_LATCH_SET) latch_ff <= 1'b1;
      else if (rx == OP_LATCH_CLR) latch_ff <= 1'b0;
    end
  end
endmodule // see_mem

// File: design/see_mst.sv
// SPI master end with APB registers and interrupt
`timescale 1ns/10ps
module see_mst
  import see_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // APB
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Interrupt
  output logic irq,
  // Serial link
  see_if.mst lnk
);
  typedef enum logic [2:0] {M_IDLE = 3'h1, M_LOW = 3'h2, M_HIGH = 3'h4} see_mst_st_t;

  // ----------------------------------------
  // Registers
  // ----------------------------------------
  logic [7:0] txd_ff, rxd_ff;
  logic last_ff, hold_ff, guard_ff, cs_n_ff, sck_ff, si_ff;
  logic [1:0] irq_ff, mask_ff;
  logic [1:0] so_s_ff;
  logic [2:0] bit_ff;
  logic [7:0] div_ff;
  see_mst_st_t st_ff;
  wire logic wr = psel & penable & pwrite;
  wire logic go = wr && paddr == REG_CTRL && pwdata[CTRL_GO] && st_ff == M_IDLE;
  wire logic tick = div_ff == 8'(SCK_HALF - 1);
  wire logic byte_end = st_ff == M_HIGH && tick && bit_ff == 3'h7;

  assign pready = 1'b1;
  assign pslverr = 1'b0;
  // Read data loaded in the setup cycle, stands through access
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      prdata <= 32'h0;
    end else if (psel && !penable) begin
      case (paddr)
        REG_CTRL: prdata <= {28'h0, guard_ff, hold_ff, last_ff, 1'b0};
        REG_TXD: prdata <= {24'h0, txd_ff};
        REG_RXD: prdata <= {24'h0, rxd_ff};
        REG_STAT: prdata <= {30'h0, ~cs_n_ff, st_ff != M_IDLE};
        REG_IRQ: prdata <= {30'h0, irq_ff};
        REG_MASK: prdata <= {30'h0, mask_ff};
        default: prdata <= 32'h0;
      endcase
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      txd_ff <= 8'h00;
      last_ff <= 1'b0;
      hold_ff <= 1'b0;
      guard_ff <= 1'b0;
      mask_ff <= 2'h0;
    end else if (wr) begin
      if (paddr == REG_CTRL) begin
        last_ff <= pwdata[CTRL_LAST];
        hold_ff <= pwdata[CTRL_HOLD];
        guard_ff <= pwdata[CTRL_GUARD];
      end
      if (paddr == REG_TXD) txd_ff <= pwdata[7:0];
      if (paddr == REG_MASK) mask_ff <= pwdata[1:0];
    end
  end

  // ----------------------------------------
  // Sticky events: byte done, frame ended
  // ----------------------------------------
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      irq_ff <= 2'h0;
    end else begin
      // Set wins over write-one-to-clear
      irq_ff <= (irq_ff & ~((wr && paddr == REG_IRQ) ? pwdata[1:0] : 2'h0))
        | {byte_end & last_ff, byte_end};
    end
  end
  assign irq = |(irq_ff & mask_ff);

  // ----------------------------------------
  // Serial engine, mode 0
  // ----------------------------------------
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      so_s_ff <= 2'h3;
    end else begin
      so_s_ff <= {so_s_ff[0], lnk.serial_out};
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      st_ff <= M_IDLE;
      div_ff <= 8'h0;
      bit_ff <= 3'h0;
      cs_n_ff <= 1'b1;
      sck_ff <= 1'b0;
      si_ff <= 1'b0;
      rxd_ff <= 8'h00;
    end else begin
      case (st_ff)
        M_IDLE: begin
          div_ff <= 8'h0;
          if (go) begin
            cs_n_ff <= 1'b0;
            si_ff <= txd_ff[7];
            bit_ff <= 3'h0;
            st_ff <= M_LOW;
          end
        end
        M_LOW: begin
          div_ff <= tick ? 8'h0 : div_ff + 8'h1;
          if (tick && !hold_ff) begin
            // Rising edge: device and master sample
            sck_ff <= 1'b1;
            rxd_ff <= {rxd_ff[6:0], so_s_ff[1]};
            st_ff <= M_HIGH;
          end
        end
        M_HIGH: begin
          div_ff <= tick ? 8'h0 : div_ff + 8'h1;
          if (tick) begin
            sck_ff <= 1'b0;
            bit_ff <= bit_ff + 3'h1;
            si_ff <= txd_ff[3'h6 - bit_ff];
            if (bit_ff == 3'h7) begin
              cs_n_ff <= ~last_ff ? 1'b0 : 1'b1;
              st_ff <= M_IDLE;
            end else begin
              st_ff <= M_LOW;
            end
          end
        end
        default: st_ff <= M_IDLE;
      endcase
    end
  end

  assign lnk.sck = sck_ff;
  assign lnk.chip_enable_n = cs_n_ff;
  assign lnk.serial_in = si_ff;
  assign lnk.hold_n = ~hold_ff;
  assign lnk.program_guard_n = ~guard_ff;
endmodule // see_mst

// File: verification/see_properties.sv
// Link-level assertions for the EEPROM master and device pair
`timescale 1ns/10ps
module see_properties (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Serial link
  input wire logic sck,
  input wire logic chip_enable_n,
  input wire logic serial_in,
  input wire logic hold_n,
  input wire logic serial_out_o,
  input wire logic serial_out_oe
);
  logic [2:0] bit_cnt_ff;
  logic sck_q_ff;
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  // Bits seen in a frame, mod 8; sampled directly as sck is registered
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      bit_cnt_ff <= 3'h0;
      sck_q_ff <= 1'b0;
    end else begin
      sck_q_ff <= sck;
      if (chip_enable_n)
        bit_cnt_ff <= 3'h0;
      else if (sck && !sck_q_ff)
        bit_cnt_ff <= bit_cnt_ff + 3'h1;
    end
  end
  a_sck_idle_low: assert property (chip_enable_n |-> !sck)
    else $error("sck high while deselected");
  a_cs_byte_bound: assert property ($rose(chip_enable_n) |-> $past(bit_cnt_ff) == 3'h0)
    else $error("deselect off a byte boundary");
  a_sck_high_len: assert property ($rose(sck) |-> sck[*6] ##1 !sck)
    else $error("sck high phase length wrong");
  a_sck_low_len: assert property ($fell(sck) |-> (!sck)[*6])
    else $error("sck low phase too short");
  a_si_stable_high: assert property (sck && $past(sck) |-> $stable(serial_in))
    else $error("serial_in moved while sck high");
  a_out_fall_only: assert property (serial_out_oe && $past(serial_out_oe) && $changed(serial_out_o) |-> !sck)
    else $error("serial_out moved while sck high");
  a_out_quiet_idle: assert property (chip_enable_n[*6] |-> !serial_out_oe)
    else $error("device drives while deselected");
  a_reset_idle: assert property ($rose(rst_n) |-> chip_enable_n && hold_n && !serial_out_oe)
    else $error("link not idle after reset");
endmodule // see_properties

// File: verification/spi_eeprom_write_protocol_tb.sv
// Self-checking bench for the EEPROM master and device pair
`timescale 1ns/10ps
module spi_eeprom_write_protocol_tb
  import see_pkg::*;
;
  // Short programming time keeps the run small
  localparam int PCYC = 2000;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic irq;
  logic guard = 1'b0;
  logic [31:0] got_v;
  logic [31:0] rd_v;
  logic err_v;
  logic [31:0] exp_q[$];
  logic [7:0] pg[16];
  logic [7:0] sv;
  int n_fail = 0;
  int comparisons = 0;
  event got_ev;
  see_if lnk();
  see_mst see_mst_inst (.clk(clk), .rst_n(rst_n), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .irq(irq),
    .lnk(lnk.mst));
  see_mem #(.PROG_CYC(PCYC)) see_mem_inst (.clk(clk), .rst_n(rst_n), .lnk(lnk.mem));
  see_properties see_properties_inst (.clk(clk), .rst_n(rst_n), .sck(lnk.sck),
    .chip_enable_n(lnk.chip_enable_n), .serial_in(lnk.serial_in), .hold_n(lnk.hold_n),
    .serial_out_o(lnk.serial_out_o), .serial_out_oe(lnk.serial_out_oe));
  always #5 clk = ~clk;
  // --------
  // Tasks
  // --------
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    @(posedge clk);
    // Ends once pready is high; otherwise the watchdog ends this wait
    while (pready !== 1'b1) begin
      @(posedge clk);
    end
    rd_v = prdata;
    err_v = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic note(input logic [31:0] e, input logic [31:0] g);
    exp_q.push_back(e);
    got_v = g;
    -> got_ev;
    #1;
  endtask
  task automatic xfer(input logic [7:0] b, input logic last);
    apb(1'b1, REG_TXD, {24'h0, b});
    apb(1'b1, REG_CTRL, {28'h0, guard, 1'b0, last, 1'b1});
    rd_v = 32'h1;
    // Unknown busy keeps waiting; the watchdog catches a hang
    while (rd_v[0] !== 1'b0) begin
      apb(1'b0, REG_STAT, 32'h0);
    end
  endtask
  task automatic stat(input logic [7:0] e);
    xfer(OP_STAT_RD, 1'b0);
    xfer(8'h00, 1'b1);
    apb(1'b0, REG_RXD, 32'h0);
    note({24'h0, e}, {24'h0, rd_v[7:0]});
  endtask
  task automatic rdn(input logic [7:0] a, input int n);
    xfer(OP_ARR_RD, 1'b0);
    xfer(a, 1'b0);
    for (int i = 0; i < n; i++) begin
      xfer(8'h00, i == n - 1);
      apb(1'b0, REG_RXD, 32'h0);
      note({24'h0, pg[4'(a + i)]}, {24'h0, rd_v[7:0]});
    end
  endtask
  // Never sends FF, so a refused read cannot pass by luck
  task automatic wrn(input logic [7:0] a, input int n, input logic en);
    logic [7:0] d;
    xfer(OP_ARR_WR, 1'b0);
    xfer(a, 1'b0);
    for (int i = 0; i < n; i++) begin
      d = 8'($urandom % 255);
      if (en)
        pg[4'(a + i)] = d;
      xfer(d, i == n - 1);
    end
  endtask
  task automatic wrap_up();
    $display("comparisons=%0d n_fail=%0d", comparisons, n_fail);
    if (n_fail == 0 && comparisons > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask
  // --------
  // Checking and sequence
  // --------
  initial begin
    logic [31:0] e;
    forever begin
      @(got_ev);
      e = exp_q.pop_front();
      comparisons++;
      if (got_v !== e) begin
        n_fail++;
        $display("[ERR] t=%0t exp=%h got=%h", $time, e, got_v);
      end
    end
  end
  initial begin
    repeat (60000) @(posedge clk);
    n_fail++;
    wrap_up();
  end
  initial begin
    void'($urandom(32'h7ca584d9));
    foreach (pg[i]) pg[i] = ERASED_BYTE;
    repeat (8) @(posedge clk);
    rst_n <= 1'b1;
    apb(1'b0, REG_MASK, 32'h0);
    note(32'h0, rd_v);
    stat(8'hF0);
    rdn(8'h40, 16);
    $display("test delivered done");
    xfer(OP_LATCH_SET, 1'b0);
    xfer(OP_LATCH_CLR, 1'b1);
    stat(8'hF2);
    xfer(OP_LATCH_CLR, 1'b1);
    stat(8'hF0);
    wrn(8'h40, 1, 1'b0);
    stat(8'hF0);
    rdn(8'h40, 1);
    $display("test latch done");
    xfer(OP_LATCH_SET, 1'b1);
    wrn(8'h45, 1, 1'b1);
    stat(8'hF3);
    sv = pg[5];
    pg[5] = ERASED_BYTE;
    rdn(8'h45, 1);
    pg[5] = sv;
    repeat (PCYC) @(posedge clk);
    stat(8'hF0);
    rdn(8'h45, 1);
    $display("test byte write done");
    xfer(OP_LATCH_SET, 1'b1);
    wrn(8'h4E, 17, 1'b1);
    repeat (PCYC) @(posedge clk);
    rdn(8'h40, 16);
    $display("test page wrap done");
    xfer(OP_LATCH_SET, 1'b1);
    guard = 1'b1;
    apb(1'b1, REG_CTRL, 32'h8);
    stat(8'hF0);
    guard = 1'b0;
    apb(1'b1, REG_CTRL, 32'h0);
    xfer(OP_LATCH_SET, 1'b1);
    xfer(OP_STAT_WR, 1'b0);
    xfer(8'h0C, 1'b1);
    stat(8'hF3);
    repeat (PCYC) @(posedge clk);
    stat(8'hFC);
    $display("test status write done");
    apb(1'b0, REG_IRQ, 32'h0);
    note(32'h3, rd_v);
    note(32'h0, {31'h0, irq});
    apb(1'b1, REG_MASK, 32'h2);
    @(posedge clk);
    note(32'h1, {31'h0, irq});
    apb(1'b1, REG_IRQ, 32'h3);
    @(posedge clk);
    note(32'h0, {31'h0, irq});
    apb(1'b0, REG_IRQ, 32'h0);
    note(32'h0, rd_v);
    apb(1'b0, 8'h1C, 32'h0);
    note(32'h0, rd_v);
    note(32'h0, {31'h0, err_v});
    $display("test registers done");
    wrap_up();
  end
endmodule // spi_eeprom_write_protocol_tb
